// ==== rtl/splle_params.svh ====
// Constants of the serial packet loader: byte codes, lengths, status codes and timing.
// Assumes it is included by the design modules and the testbench; the package does not include it.
`ifndef SPLLE_PARAMS_SVH
`define SPLLE_PARAMS_SVH

// Packet acknowledge bytes
`define SPLLE_ACK 8'hcc
`define SPLLE_NAK 8'h33

// Command codes
`define SPLLE_CMD_PING 8'h20
`define SPLLE_CMD_DOWNLOAD 8'h21
`define SPLLE_CMD_RUN 8'h22
`define SPLLE_CMD_STATUS 8'h23
`define SPLLE_CMD_SEND_DATA 8'h24
`define SPLLE_CMD_RESET 8'h25

// Packet lengths, counting length and checksum bytes
`define SPLLE_MIN_LEN 8'h03
`define SPLLE_LEN_SHORT 8'h03
`define SPLLE_LEN_DOWNLOAD 8'h0b
`define SPLLE_LEN_RUN 8'h07
`define SPLLE_STATUS_PKT_LEN 8'h03
`define SPLLE_HDR_BYTES 8'h02

// Stored status codes
`define SPLLE_ST_SUCCESS 8'h40
`define SPLLE_ST_UNKNOWN_CMD 8'h41
`define SPLLE_ST_BAD_ADDR 8'h43
`define SPLLE_ST_FLASH_FAIL 8'h44

// Target size in bytes and inter-byte gap limit
`define SPLLE_FLASH_BYTES 32'h0004_0000
`define SPLLE_GAP_TIMEOUT_NS 1000000
`define SPLLE_CLK_PERIOD_NS 100

`endif

// ==== rtl/splle_pkg.sv ====
// Types shared by the serial packet loader modules.
// Assumes the constants header sits beside it in rtl/.
package splle_pkg;

	// One byte with its valid flag, for serial byte streams
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} splle_byte_t;

	// Request to the flash sequencer: one-cycle strobes with address, count and data
	typedef struct packed {
		logic erase;
		logic prog;
		logic [31:0] addr;
		logic [31:0] count;
		logic [7:0] data;
	} splle_flash_req_t;

	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_SUM = 4'h1,
		S_DATA = 4'h2,
		S_CHECK = 4'h3,
		S_ERASE = 4'h4,
		S_PROG = 4'h5,
		S_PROG_WAIT = 4'h6,
		S_SEND_ACK = 4'h7,
		S_WAIT_TX = 4'h8,
		S_SEND_PKT = 4'h9,
		S_WAIT_PKT = 4'ha,
		S_WAIT_HACK = 4'hb
	} splle_state_t;

	// What follows once the acknowledge byte has left
	typedef enum logic [1:0] {
		A_NONE = 2'h0,
		A_PKT = 2'h1,
		A_RUN = 2'h2,
		A_RESET = 2'h3
	} splle_after_t;

endpackage

// ==== rtl/splle_port_lock.sv ====
// Port selector: forwards bytes from the serial ports and locks onto the first one that talks.
// Assumes every port delivers bytes synchronous to clk as one-cycle valid strobes.
`timescale 1ns/100ps
`include "splle_params.svh"
module splle_port_lock import splle_pkg::*; #(
	parameter int NUM_PORTS = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input splle_byte_t [NUM_PORTS-1:0] rx_in,
	output splle_byte_t rx_out,
	output logic [$clog2(NUM_PORTS)-1:0] sel_out,
	output logic locked_out
);
	splle_byte_t out_reg, out_next;
	logic [$clog2(NUM_PORTS)-1:0] sel_reg, sel_next;
	logic locked_reg, locked_next;

	if (NUM_PORTS < 2) begin : g_chk
		$error("splle_port_lock needs at least two ports");
	end

	// Before locking the lowest talking port wins; zero filler never locks
	always_comb begin
		out_next = '0;
		sel_next = sel_reg;
		locked_next = locked_reg;
		if (locked_reg) begin
			out_next = rx_in[sel_reg];
		end else begin
			// A zero on a lower port must not hide a length byte that arrives on a higher one
			for (int i = NUM_PORTS - 1; i >= 0; i--) begin
				if (rx_in[i].valid && (rx_in[i].data != 8'h00 || out_next.data == 8'h00)) begin
					out_next = rx_in[i];
					if (rx_in[i].data != 8'h00) begin
						sel_next = ($clog2(NUM_PORTS))'(i);
						locked_next = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			out_reg <= '0;
			sel_reg <= '0;
			locked_reg <= 1'b0;
		end else if (ce) begin
			out_reg <= out_next;
			sel_reg <= sel_next;
			locked_reg <= locked_next;
		end
	end

	assign rx_out = out_reg;
	assign sel_out = sel_reg;
	assign locked_out = locked_reg;

	a_lock_sticky: assert property (@(posedge clk) disable iff (rst)
		ce && locked_reg |=> locked_reg && $stable(sel_reg))
		else $error("port lock changed after locking");
endmodule

// ==== rtl/splle_tx.sv ====
// Transmit sequencer: sends a single acknowledge byte or a one-byte status packet.
// Assumes the serial port takes a byte in each cycle where valid and tx_ready are both high.
`timescale 1ns/100ps
`include "splle_params.svh"
module splle_tx import splle_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic start,
	input wire logic is_pkt,
	input wire logic [7:0] byte_in,
	input wire logic tx_ready,
	output splle_byte_t tx_out,
	output logic busy
);
	splle_byte_t out_reg, out_next;
	logic busy_reg, busy_next;
	logic pkt_reg, pkt_next;
	logic [1:0] idx_reg, idx_next;
	logic [7:0] stat_reg, stat_next;

	// Packet bytes follow each other with no filler once the length byte is out
	always_comb begin
		out_next = out_reg;
		busy_next = busy_reg;
		pkt_next = pkt_reg;
		idx_next = idx_reg;
		stat_next = stat_reg;
		if (!busy_reg && start) begin
			busy_next = 1'b1;
			pkt_next = is_pkt;
			stat_next = byte_in;
			idx_next = 2'h0;
			out_next.valid = 1'b1;
			out_next.data = is_pkt ? `SPLLE_STATUS_PKT_LEN : byte_in;
		end else if (busy_reg && out_reg.valid && tx_ready) begin
			if (pkt_reg && idx_reg < 2'h2) begin
				idx_next = idx_reg + 2'h1;
				out_next.data = stat_reg;
			end else begin
				out_next = '0;
				busy_next = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			out_reg <= '0;
			busy_reg <= 1'b0;
			pkt_reg <= 1'b0;
			idx_reg <= 2'h0;
			stat_reg <= 8'h00;
		end else if (ce) begin
			out_reg <= out_next;
			busy_reg <= busy_next;
			pkt_reg <= pkt_next;
			idx_reg <= idx_next;
			stat_reg <= stat_next;
		end
	end

	assign tx_out = out_reg;
	assign busy = busy_reg;

	a_len_leads_pkt: assert property (@(posedge clk) disable iff (rst)
		ce && !busy_reg && start && is_pkt |=> out_reg.valid && out_reg.data == `SPLLE_STATUS_PKT_LEN)
		else $error("status packet did not open with its length");

	a_pkt_back_to_back: assert property (@(posedge clk) disable iff (rst)
		ce && busy_reg && pkt_reg && out_reg.valid && idx_reg < 2'h2 |=> out_reg.valid)
		else $error("gap inside an outgoing packet");
endmodule

// ==== rtl/splle_loader.sv ====
// Serial packet loader: frames, checks and acknowledges host packets and runs their commands.
// Assumes byte-level serial ports, a flash sequencer that answers each strobe with flash_done,
// and a chip reset that follows soft_reset_req.
// How it works
// - First byte of each packet is total length including length and checksum bytes
// - Second byte is the sum of payload bytes only
// - After each packet send 0xcc when good, 0x33 when not
// - Acknowledge reflects framing only; command validity goes to status
// - Outgoing packet: optional zeros, then length, checksum, payload
// - After the length byte the rest leaves back to back
// - While awaiting host acknowledge, zeros are skipped, first nonzero taken
// - First payload byte is the command, the rest its parameters
// - Ping, 0x20 in length 3: acknowledge and set status success
// - Download 0x21 in 11 bytes: address then count, both MSB first
// - Download erases the region before acknowledging, then holds pointer and count
// - Run 0x22 in 7 bytes: acknowledge first, then hand over execution
// - Status query 0x23: return one-byte status packet, then await host acknowledge
// - Send-data 0x24 programs at the pointer and advances it
// - Programming stops once the downloaded count is reached
// - A negatively acknowledged send-data leaves the pointer alone
// - Reset 0x25 in 3 bytes: acknowledge first, then soft reset
// - Once a port has talked, all others are ignored until reset
`timescale 1ns/100ps
`include "splle_params.svh"
module splle_loader import splle_pkg::*; #(
	parameter int NUM_PORTS = 2,
	parameter int MAX_PAYLOAD = 253,
	parameter int GAP_CYCLES = `SPLLE_GAP_TIMEOUT_NS / `SPLLE_CLK_PERIOD_NS,
	parameter logic [31:0] FLASH_BYTES = `SPLLE_FLASH_BYTES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input splle_byte_t [NUM_PORTS-1:0] rx_in,
	input wire logic tx_ready,
	output splle_byte_t tx_out,
	output logic [$clog2(NUM_PORTS)-1:0] port_sel,
	output logic port_locked,
	output splle_flash_req_t flash_req,
	input wire logic flash_done,
	input wire logic flash_err,
	output logic run_req,
	output logic [31:0] run_addr,
	output logic soft_reset_req,
	output logic [7:0] status_code
);
	localparam logic [7:0] MAX_LEN8 = 8'(MAX_PAYLOAD);

	if (MAX_PAYLOAD < 9 || MAX_PAYLOAD > 253 || GAP_CYCLES < 2) begin : g_chk
		$error("splle_loader parameters out of range");
	end

	// Big-endian assembly of a 32-bit parameter
	function automatic logic [31:0] splle_be32(input logic [7:0] b3, input logic [7:0] b2,
		input logic [7:0] b1, input logic [7:0] b0);
		return {b3, b2, b1, b0};
	endfunction

	splle_byte_t rx;
	logic tx_busy;
	logic tx_start;
	logic tx_is_pkt;
	logic [7:0] tx_byte;

	splle_port_lock #(.NUM_PORTS(NUM_PORTS)) u_lock (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.rx_in(rx_in),
		.rx_out(rx),
		.sel_out(port_sel),
		.locked_out(port_locked)
	);

	splle_tx u_tx (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.start(tx_start),
		.is_pkt(tx_is_pkt),
		.byte_in(tx_byte),
		.tx_ready(tx_ready),
		.tx_out(tx_out),
		.busy(tx_busy)
	);

	splle_state_t state_reg, state_next;
	splle_after_t after_reg, after_next;
	logic [7:0] len_reg, len_next;
	logic [7:0] exp_reg, exp_next;
	logic [7:0] acc_reg, acc_next;
	logic [7:0] cnt_reg, cnt_next;
	logic [7:0] idx_reg, idx_next;
	logic [31:0] gap_reg, gap_next;
	logic ack_ok_reg, ack_ok_next;
	logic [7:0] status_reg, status_next;
	logic [31:0] ptr_reg, ptr_next;
	logic [31:0] remain_reg, remain_next;
	splle_flash_req_t freq_reg, freq_next;
	logic run_reg, run_next;
	logic [31:0] raddr_reg, raddr_next;
	logic srst_reg, srst_next;
	logic [7:0] pay_mem [MAX_PAYLOAD];
	logic mem_we;
	logic [31:0] dl_addr;
	logic [31:0] dl_size;
	logic frame_good;

	// Payload parameters and frame check, read in the check state
	assign dl_addr = splle_be32(pay_mem[1], pay_mem[2], pay_mem[3], pay_mem[4]);
	assign dl_size = splle_be32(pay_mem[5], pay_mem[6], pay_mem[7], pay_mem[8]);
	assign frame_good = (acc_reg == exp_reg) && ((len_reg - `SPLLE_HDR_BYTES) <= MAX_LEN8);
	assign tx_start = (state_reg == S_SEND_ACK) || (state_reg == S_SEND_PKT);
	assign tx_is_pkt = (state_reg == S_SEND_PKT);
	assign tx_byte = tx_is_pkt ? status_reg : (ack_ok_reg ? `SPLLE_ACK : `SPLLE_NAK);

	// Frame reception, command execution and answer sequencing
	always_comb begin
		state_next = state_reg;
		after_next = after_reg;
		len_next = len_reg;
		exp_next = exp_reg;
		acc_next = acc_reg;
		cnt_next = cnt_reg;
		idx_next = idx_reg;
		gap_next = 32'h0000_0000;
		ack_ok_next = ack_ok_reg;
		status_next = status_reg;
		ptr_next = ptr_reg;
		remain_next = remain_reg;
		freq_next = freq_reg;
		freq_next.erase = 1'b0;
		freq_next.prog = 1'b0;
		run_next = 1'b0;
		raddr_next = raddr_reg;
		srst_next = 1'b0;
		mem_we = 1'b0;
		case (state_reg)
			S_IDLE: begin
				if (rx.valid && rx.data != 8'h00) begin
					len_next = rx.data;
					state_next = S_SUM;
				end
			end
			S_SUM, S_DATA: begin
				gap_next = rx.valid ? 32'h0000_0000 : gap_reg + 32'h0000_0001;
				if (gap_reg == 32'(GAP_CYCLES - 1)) begin
					// A stalled frame has fewer bytes than announced
					ack_ok_next = 1'b0;
					after_next = A_NONE;
					state_next = S_SEND_ACK;
				end else if (rx.valid && state_reg == S_SUM) begin
					exp_next = rx.data;
					acc_next = 8'h00;
					cnt_next = 8'h00;
					ack_ok_next = 1'b0;
					after_next = A_NONE;
					state_next = (len_reg < `SPLLE_MIN_LEN) ? S_SEND_ACK : S_DATA;
				end else if (rx.valid) begin
					mem_we = (cnt_reg < MAX_LEN8);
					acc_next = acc_reg + rx.data;
					cnt_next = cnt_reg + 8'h01;
					if (cnt_next == len_reg - `SPLLE_HDR_BYTES) begin
						state_next = S_CHECK;
					end
				end
			end
			S_CHECK: begin
				// Acknowledge follows the frame check; a bad command only shows in status
				ack_ok_next = frame_good;
				after_next = A_NONE;
				state_next = S_SEND_ACK;
				if (frame_good) begin
					status_next = `SPLLE_ST_UNKNOWN_CMD;
					case (pay_mem[0])
						`SPLLE_CMD_PING: begin
							if (len_reg == `SPLLE_LEN_SHORT) begin
								status_next = `SPLLE_ST_SUCCESS;
							end
						end
						`SPLLE_CMD_DOWNLOAD: begin
							if (len_reg == `SPLLE_LEN_DOWNLOAD) begin
								remain_next = 32'h0000_0000;
								if ({1'b0, dl_addr} + {1'b0, dl_size} > {1'b0, FLASH_BYTES}) begin
									status_next = `SPLLE_ST_BAD_ADDR;
								end else begin
									ptr_next = dl_addr;
									remain_next = dl_size;
									freq_next.erase = 1'b1;
									freq_next.addr = dl_addr;
									freq_next.count = dl_size;
									state_next = S_ERASE;
								end
							end
						end
						`SPLLE_CMD_RUN: begin
							if (len_reg == `SPLLE_LEN_RUN) begin
								status_next = `SPLLE_ST_SUCCESS;
								raddr_next = dl_addr;
								after_next = A_RUN;
							end
						end
						`SPLLE_CMD_STATUS: begin
							if (len_reg == `SPLLE_LEN_SHORT) begin
								status_next = status_reg;
								after_next = A_PKT;
							end
						end
						`SPLLE_CMD_SEND_DATA: begin
							if (remain_reg == 32'h0000_0000) begin
								status_next = `SPLLE_ST_BAD_ADDR;
							end else begin
								idx_next = 8'h01;
								state_next = S_PROG;
							end
						end
						`SPLLE_CMD_RESET: begin
							if (len_reg == `SPLLE_LEN_SHORT) begin
								status_next = `SPLLE_ST_SUCCESS;
								after_next = A_RESET;
							end
						end
						default: begin
							status_next = `SPLLE_ST_UNKNOWN_CMD;
						end
					endcase
				end
			end
			S_ERASE: begin
				if (flash_done) begin
					// Acknowledge waits for the erase to finish
					status_next = flash_err ? `SPLLE_ST_FLASH_FAIL : `SPLLE_ST_SUCCESS;
					remain_next = flash_err ? 32'h0000_0000 : remain_reg;
					state_next = S_SEND_ACK;
				end
			end
			S_PROG: begin
				if (idx_reg == len_reg - `SPLLE_HDR_BYTES || remain_reg == 32'h0000_0000) begin
					status_next = `SPLLE_ST_SUCCESS;
					state_next = S_SEND_ACK;
				end else begin
					freq_next.prog = 1'b1;
					freq_next.addr = ptr_reg;
					freq_next.count = 32'h0000_0001;
					freq_next.data = pay_mem[idx_reg];
					state_next = S_PROG_WAIT;
				end
			end
			S_PROG_WAIT: begin
				if (flash_done && flash_err) begin
					status_next = `SPLLE_ST_FLASH_FAIL;
					remain_next = 32'h0000_0000;
					state_next = S_SEND_ACK;
				end else if (flash_done) begin
					ptr_next = ptr_reg + 32'h0000_0001;
					remain_next = remain_reg - 32'h0000_0001;
					idx_next = idx_reg + 8'h01;
					state_next = S_PROG;
				end
			end
			S_SEND_ACK: begin
				state_next = S_WAIT_TX;
			end
			S_WAIT_TX: begin
				if (!tx_busy) begin
					state_next = (after_reg == A_PKT) ? S_SEND_PKT : S_IDLE;
					run_next = (after_reg == A_RUN);
					srst_next = (after_reg == A_RESET);
				end
			end
			S_SEND_PKT: begin
				state_next = S_WAIT_PKT;
			end
			S_WAIT_PKT: begin
				if (!tx_busy) begin
					state_next = S_WAIT_HACK;
				end
			end
			S_WAIT_HACK: begin
				if (rx.valid && rx.data != 8'h00) begin
					state_next = S_IDLE;
				end
			end
			default: begin
				state_next = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= S_IDLE;
			after_reg <= A_NONE;
			len_reg <= 8'h00;
			exp_reg <= 8'h00;
			acc_reg <= 8'h00;
			cnt_reg <= 8'h00;
			idx_reg <= 8'h00;
			gap_reg <= 32'h0000_0000;
			ack_ok_reg <= 1'b0;
			status_reg <= `SPLLE_ST_SUCCESS;
			ptr_reg <= 32'h0000_0000;
			remain_reg <= 32'h0000_0000;
			freq_reg <= '0;
			run_reg <= 1'b0;
			raddr_reg <= 32'h0000_0000;
			srst_reg <= 1'b0;
		end else if (ce) begin
			state_reg <= state_next;
			after_reg <= after_next;
			len_reg <= len_next;
			exp_reg <= exp_next;
			acc_reg <= acc_next;
			cnt_reg <= cnt_next;
			idx_reg <= idx_next;
			gap_reg <= gap_next;
			ack_ok_reg <= ack_ok_next;
			status_reg <= status_next;
			ptr_reg <= ptr_next;
			remain_reg <= remain_next;
			freq_reg <= freq_next;
			run_reg <= run_next;
			raddr_reg <= raddr_next;
			srst_reg <= srst_next;
		end
	end

	// Payload store; bytes beyond capacity are counted but dropped and the frame is refused
	always_ff @(posedge clk) begin
		if (ce && mem_we) begin
			pay_mem[cnt_reg] <= rx.data;
		end
	end

	assign flash_req = freq_reg;
	assign run_req = run_reg;
	assign run_addr = raddr_reg;
	assign soft_reset_req = srst_reg;
	assign status_code = status_reg;

	a_nak_bad_sum: assert property (@(posedge clk) disable iff (rst)
		ce && state_reg == S_CHECK && acc_reg != exp_reg |=> state_reg == S_SEND_ACK && !ack_ok_reg)
		else $error("bad checksum not refused");

	a_ack_codes: assert property (@(posedge clk) disable iff (rst)
		ce && state_reg == S_SEND_ACK |=> tx_out.valid && tx_out.data inside {`SPLLE_ACK, `SPLLE_NAK})
		else $error("acknowledge byte has a wrong code");

	a_ping_status: assert property (@(posedge clk) disable iff (rst)
		ce && state_reg == S_CHECK && frame_good && pay_mem[0] == `SPLLE_CMD_PING && len_reg == `SPLLE_LEN_SHORT
		|=> status_reg == `SPLLE_ST_SUCCESS && ack_ok_reg)
		else $error("ping did not set success");

	a_erase_then_ack: assert property (@(posedge clk) disable iff (rst)
		ce && state_reg == S_ERASE && !flash_done |=> state_reg == S_ERASE)
		else $error("acknowledge left before erase finished");

	a_run_after_ack: assert property (@(posedge clk) disable iff (rst)
		run_reg |-> $past(state_reg) == S_WAIT_TX && !$past(tx_busy))
		else $error("run issued before acknowledge was sent");

	a_reset_after_ack: assert property (@(posedge clk) disable iff (rst)
		srst_reg |-> $past(state_reg) == S_WAIT_TX && $past(after_reg) == A_RESET)
		else $error("reset issued before acknowledge was sent");

	a_ptr_kept_on_nak: assert property (@(posedge clk) disable iff (rst)
		ce && state_reg == S_CHECK && !frame_good |=> $stable(ptr_reg) ##1 $stable(ptr_reg))
		else $error("pointer moved on a refused packet");

	a_prog_within_count: assert property (@(posedge clk) disable iff (rst)
		freq_reg.prog |-> remain_reg != 32'h0000_0000)
		else $error("programming beyond the downloaded count");
endmodule

// ==== verif/splle_host_model.sv ====
// Host model: frames packets onto the serial ports and collects the bytes the loader sends.
// Assumes the loader samples rx_in on rising edges and holds tx_out.valid until taken.
`timescale 1ns/100ps
module splle_host_model import splle_pkg::*; (
	input wire logic clk,
	input splle_byte_t tx_out,
	output splle_byte_t [1:0] rx_in,
	output logic tx_ready
);
	logic [7:0] got_q[$];
	logic [1:0] stall_cnt;
	initial begin
		rx_in = '0;
		tx_ready = 1'b0;
		stall_cnt = 2'h0;
	end
	// Stall one cycle in four so the loader has to hold each byte
	always @(negedge clk) begin
		stall_cnt <= stall_cnt + 2'h1;
		tx_ready <= (stall_cnt != 2'h3);
	end
	// Zeros ahead of an answer are dropped; later zeros are kept so filler shows up
	always @(posedge clk) begin
		if (tx_out.valid && tx_ready && (tx_out.data != 8'h00 || got_q.size() != 0)) begin
			got_q.push_back(tx_out.data);
		end
	end
	// Bytes go back to back, one strobe per cycle
	task automatic send_raw(input int port, input logic [7:0] fr[$]);
		foreach (fr[i]) begin
			@(negedge clk);
			rx_in[port] <= {1'b1, fr[i]};
		end
		@(negedge clk);
		rx_in[port] <= '0;
	endtask
	// Length counts both header bytes; sum covers the payload only, kept to eight bits
	task automatic send_frame(input int port, input logic [7:0] pl[$], input logic [7:0] sum_err);
		logic [7:0] sum;
		logic [7:0] fr[$];
		sum = 8'h00;
		foreach (pl[i]) sum = sum + pl[i];
		fr = pl;
		fr.push_front(sum ^ sum_err);
		fr.push_front(8'(pl.size() + 2));
		send_raw(port, fr);
	endtask
endmodule

// ==== verif/splle_loader_tb.sv ====
// Testbench of the serial packet loader: host model on the ports, flash answered here.
// Assumes a short inter-byte gap limit and flash that always succeeds.
`timescale 1ns/100ps
`include "splle_params.svh"
module splle_loader_tb import splle_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	splle_byte_t [1:0] rx_in;
	logic tx_ready;
	splle_byte_t tx_out;
	logic port_sel;
	logic port_locked;
	splle_flash_req_t flash_req;
	logic flash_done = 1'b0;
	logic flash_err = 1'b0;
	logic run_req;
	logic [31:0] run_addr;
	logic soft_reset_req;
	logic [7:0] status_code;
	int n_mismatch = 0;
	int total_checks = 0;
	int cyc = 0;
	int fl_wait = 0;
	int n_erase = 0;
	int n_run = 0;
	int n_srst = 0;
	logic [31:0] er_addr;
	logic [31:0] er_cnt;
	logic [15:0] prog_q[$];
	logic [7:0] pl[$];
	logic [7:0] ex[$];

	splle_loader #(.NUM_PORTS(2), .GAP_CYCLES(20)) DUT (.clk(clk), .rst(rst), .ce(ce), .rx_in(rx_in),
		.tx_ready(tx_ready), .tx_out(tx_out), .port_sel(port_sel), .port_locked(port_locked),
		.flash_req(flash_req), .flash_done(flash_done), .flash_err(flash_err), .run_req(run_req),
		.run_addr(run_addr), .soft_reset_req(soft_reset_req), .status_code(status_code));
	splle_host_model host (.clk(clk), .tx_out(tx_out), .rx_in(rx_in), .tx_ready(tx_ready));

	always #50 clk = ~clk;

	// Flash answers every strobe three cycles later; strobes and pulses are logged
	always @(negedge clk) begin
		flash_done <= 1'b0;
		if (flash_req.erase || flash_req.prog) begin
			fl_wait <= 3;
			if (flash_req.erase) begin
				n_erase++;
				er_addr = flash_req.addr;
				er_cnt = flash_req.count;
			end
			if (flash_req.prog) prog_q.push_back({flash_req.addr[7:0], flash_req.data});
		end else if (fl_wait == 1) begin
			fl_wait <= 0;
			flash_done <= 1'b1;
		end else if (fl_wait != 0) fl_wait <= fl_wait - 1;
		if (run_req) n_run++;
		if (soft_reset_req) n_srst++;
	end

	// Hang guard, far above the length of the whole sequence
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d, mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// Wait, bounded, for the expected answer bytes and compare them in order
	task automatic pkt(input int port, input logic [7:0] sum_err);
		int w;
		w = 0;
		host.send_frame(port, pl, sum_err);
		while (host.got_q.size() < ex.size() && w < 300) begin
			@(negedge clk);
			w++;
		end
		repeat (8) @(negedge clk);
		check("answer length", host.got_q.size(), ex.size());
		foreach (ex[i]) check("tx byte", (host.got_q.size() > i) ? host.got_q[i] : 8'h00, ex[i]);
		host.got_q.delete();
	endtask

	// Status query answers cc then a one-byte packet; host pads with zeros before its reply
	task automatic query(input logic [7:0] st, input logic [7:0] reply);
		pl = '{`SPLLE_CMD_STATUS};
		ex = '{`SPLLE_ACK, 8'h03, st, st};
		pkt(0, 8'h00);
		host.send_raw(0, '{8'h00, 8'h00, reply});
		repeat (4) @(negedge clk);
	endtask

	task automatic t_ping_and_errors();
		pl = '{`SPLLE_CMD_PING};
		ex = '{`SPLLE_ACK};
		pkt(0, 8'h00);
		check("locked", port_locked, 1'b1);
		check("status", status_code, `SPLLE_ST_SUCCESS);
		ex = '{`SPLLE_NAK};
		pkt(0, 8'h01);
		pl = '{8'h30};
		ex = '{`SPLLE_ACK};
		pkt(0, 8'h00);
		// Length promises four bytes but only three come; the gap limit refuses the frame
		host.send_raw(0, '{8'h04, 8'h20, 8'h20});
		repeat (40) @(negedge clk);
		check("short frame", (host.got_q.size() > 0) ? host.got_q[0] : 8'h00, `SPLLE_NAK);
		host.got_q.delete();
		// Host refuses the status packet, then asks again and gets the same status
		query(`SPLLE_ST_UNKNOWN_CMD, `SPLLE_NAK);
		query(`SPLLE_ST_UNKNOWN_CMD, `SPLLE_ACK);
		pl = '{`SPLLE_CMD_PING};
		ex = '{`SPLLE_ACK};
		pkt(0, 8'h00);
	endtask

	task automatic t_download();
		pl = '{`SPLLE_CMD_DOWNLOAD, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h06};
		ex = '{`SPLLE_ACK};
		pkt(0, 8'h00);
		check("erase count", n_erase, 1);
		check("erase addr", er_addr, 32'h0000_0100);
		check("erase size", er_cnt, 32'h0000_0006);
		query(`SPLLE_ST_SUCCESS, `SPLLE_ACK);
		pl = '{`SPLLE_CMD_SEND_DATA, 8'ha0, 8'ha1, 8'ha2, 8'ha3};
		ex = '{`SPLLE_ACK};
		pkt(0, 8'h00);
		ex = '{`SPLLE_NAK};
		pl = '{`SPLLE_CMD_SEND_DATA, 8'hb0, 8'hb1, 8'hb2, 8'hb3};
		pkt(0, 8'h80);
		ex = '{`SPLLE_ACK};
		pkt(0, 8'h00);
		check("prog strobes", prog_q.size(), 6);
		foreach (prog_q[i]) check("prog", prog_q[i], (i < 4) ? {8'(i), 4'ha, 4'(i)} : {8'(i), 4'hb, 4'(i - 4)});
		query(`SPLLE_ST_SUCCESS, `SPLLE_ACK);
		// Region past the end of flash: acknowledged, refused in status, nothing erased
		pl = '{`SPLLE_CMD_DOWNLOAD, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
		ex = '{`SPLLE_ACK};
		pkt(0, 8'h00);
		check("no erase", n_erase, 1);
		query(`SPLLE_ST_BAD_ADDR, `SPLLE_ACK);
		// With no count left a data packet programs nothing
		pl = '{`SPLLE_CMD_SEND_DATA, 8'hc0, 8'hc1, 8'hc2, 8'hc3};
		ex = '{`SPLLE_ACK};
		pkt(0, 8'h00);
		check("no prog", prog_q.size(), 6);
		query(`SPLLE_ST_BAD_ADDR, `SPLLE_ACK);
	endtask

	task automatic t_run_reset_lock();
		// The other port is ignored, so no answer at all is expected
		pl = '{`SPLLE_CMD_PING};
		ex.delete();
		pkt(1, 8'h00);
		check("other port ignored", n_run + n_srst, 0);
		pl = '{`SPLLE_CMD_RUN, 8'h12, 8'h34, 8'h56, 8'h78};
		ex = '{`SPLLE_ACK};
		pkt(0, 8'h00);
		check("run pulses", n_run, 1);
		check("run addr", run_addr, 32'h1234_5678);
		pl = '{`SPLLE_CMD_RESET};
		pkt(0, 8'h00);
		check("reset pulses", n_srst, 1);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		check("unlocked", port_locked, 1'b0);
		pl = '{`SPLLE_CMD_PING};
		pkt(1, 8'h00);
		check("port sel", port_sel, 1'b1);
	endtask

	// Reset, then the scenarios in turn
	initial begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		check("reset status", status_code, `SPLLE_ST_SUCCESS);
		t_ping_and_errors();
		t_download();
		t_run_reset_lock();
		stop_test();
	end
endmodule
